// [design/ilc_consts.svh]
// Constants for the four-lane link configuration framer.
`ifndef ILC_CONSTS_SVH
`define ILC_CONSTS_SVH
`define ILC_LANES       4
`define ILC_CFG_OCTETS  14
`define ILC_ILA_MF      4
`define ILC_CFG_MF      2'h1
`define ILC_RST_F       8'h00
`define ILC_RST_K       5'h10
`define ILC_RST_L       5'h03
`define ILC_RST_M       8'h01
`define ILC_RST_N       5'h0F
`define ILC_RST_NP      5'h0F
`define ILC_RST_S       5'h00
`define ILC_RST_JESDV   3'h1
`define ILC_RST_SUBCL   3'h2
`define ILC_RST_HD      1'h1
`define ILC_K28_5       8'hBC
`define ILC_K28_0       8'h1C
`define ILC_K28_3       8'h7C
`define ILC_K28_4       8'h9C
`define ILC_K28_7       8'hFC
`define ILC_FIFO_DEPTH  4
`endif

// [design/ilc_fifo.sv]
// Small valid/ready FIFO for the lane octet stream.
`default_nettype none
module ilc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   // Pointer and fill-count update; full and empty follow the count exactly.
   always_comb begin
      push     = in_valid && (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
      pop      = out_valid && out_ready;
      wr_next  = push ? wr_reg + AW'(1) : wr_reg;
      rd_next  = pop ? rd_reg + AW'(1) : rd_reg;
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage has no reset; its output word is only valid while the count says it holds data.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end

   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem[rd_reg];
endmodule
`default_nettype wire

// [design/ilc_framer.sv]
// Four-lane initial lane alignment framer with link configuration octets.
`include "ilc_consts.svh"
`default_nettype none
module ilc_framer (
   input  wire logic          clk_sys,
   input  wire logic          arst_n,
   input  wire logic          sync_n,
   input  wire logic          mf_start,
   input  wire logic          cfg_load,
   input  wire ilc_pkg::ilc_cfg_t cfg_in,
   input  wire ilc_pkg::ilc_word_t data_in,
   output logic               data_ready,
   output ilc_pkg::ilc_word_t lane_out,
   output logic               lane_valid,
   input  wire logic          lane_ready,
   output logic               ila_active,
   output logic               link_up
);
   import ilc_pkg::*;

   ilc_state_t st_reg, st_next;
   ilc_cfg_t   cfg_reg, cfg_next;
   logic [1:0] mf_reg, mf_next;
   logic [4:0] fr_reg, fr_next;
   logic       s1_reg, s2_reg;
   ilc_word_t  word;
   logic       fifo_in_ready, fifo_out_valid, push;
   ilc_word_t  fifo_out;
   ilc_word_t  out_reg, out_next;
   logic       ov_reg, ov_next, up_reg, up_next, ila_reg, ila_next;
   // Local copy of the FIFO fill, kept in step with every push and pop.
   logic       rdy_next, fifo_pop;
   logic [2:0] fill_reg, fill_next;

   // Octet n of the configuration block for lane `lane`.
   function automatic logic [7:0] cfg_octet(input ilc_cfg_t c, input logic [4:0] lane, input logic [3:0] n);
      logic [7:0] o;
      o = 8'h00;
      case (n)
         4'h0: o = 8'h00;
         4'h1: o = 8'h00;
         4'h2: o = {2'b00, c.phadj, lane};
         4'h3: o = {c.scr, 2'b00, `ILC_RST_L};
         4'h4: o = c.f_m1;
         4'h5: o = {3'b000, c.k_m1};
         4'h6: o = c.m_m1;
         4'h7: o = {3'b000, `ILC_RST_N};
         4'h8: o = {`ILC_RST_SUBCL, `ILC_RST_NP};
         4'h9: o = {`ILC_RST_JESDV, c.s_m1};
         4'hA: o = {`ILC_RST_HD, 7'h00};
         default: o = 8'h00;
      endcase
      return o;
   endfunction

   // Checksum adds the field values themselves, not the packed octets, in an 8-bit sum that wraps at 256.
   // Fields that always go out as zero (bank, device, control, reserved) add nothing and are left out.
   // The lane identifier is the only term that differs from lane to lane.
   function automatic logic [7:0] cfg_sum(input ilc_cfg_t c, input logic [4:0] lane);
      logic [7:0] s;
      s = 8'(lane) + 8'(c.phadj) + 8'(c.scr) + 8'(`ILC_RST_L) + c.f_m1;
      s = s + 8'(c.k_m1) + c.m_m1 + 8'(`ILC_RST_N) + 8'(`ILC_RST_NP);
      s = s + 8'(`ILC_RST_SUBCL) + 8'(`ILC_RST_JESDV) + 8'(c.s_m1) + 8'(`ILC_RST_HD);
      return s;
   endfunction

   // Sync pin arrives from the receiver's domain, so it is double flopped.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
      end else begin
         s1_reg <= sync_n;
         s2_reg <= s1_reg;
      end
   end

   // Sequencer: commas, wait for boundary, four alignment multiframes, data.
   always_comb begin
      st_next  = st_reg;
      mf_next  = mf_reg;
      fr_next  = fr_reg;
      cfg_next = cfg_reg;
      word     = '0;
      push     = 1'b0;
      if (cfg_load && st_reg == ILC_CGS) begin
         cfg_next = cfg_in;
      end
      for (int l = 0; l < `ILC_LANES; l++) begin
         word.data[l] = `ILC_K28_5;
         word.is_k[l] = 1'b1;
      end
      case (st_reg)
         ILC_CGS: begin
            push = fifo_in_ready;
            if (s2_reg && push) begin
               st_next = ILC_WAIT;
            end
         end
         ILC_WAIT: begin
            // A boundary pulse that meets a full FIFO is skipped; the next one that finds room starts alignment.
            push = fifo_in_ready;
            if (push && mf_start) begin
               st_next = ILC_ILA;
               mf_next = 2'h0;
               fr_next = 5'h00;
               push    = 1'b0;
            end
         end
         ILC_ILA: begin
            push = fifo_in_ready;
            for (int l = 0; l < `ILC_LANES; l++) begin
               word.data[l] = 8'h00;
               word.is_k[l] = 1'b0;
               // Frame 1 marks the block and frames 2 to 15 carry its fourteen octets; the ILC_K28_3 at frame k_m1 overrides any of them.
               if (mf_reg == `ILC_CFG_MF && fr_reg < 5'(`ILC_CFG_OCTETS + 2)) begin
                  // Configuration only inside the second multiframe.
                  word.data[l] = (fr_reg == 5'd1) ? `ILC_K28_4 : 8'h00;
                  word.is_k[l] = (fr_reg == 5'd1);
                  if (fr_reg >= 5'd2) begin
                     word.data[l] = (fr_reg == 5'd15) ? cfg_sum(cfg_reg, 5'(l))
                                  : cfg_octet(cfg_reg, 5'(l), 4'(fr_reg - 5'd2));
                  end
                  if (fr_reg == 5'd15) begin
                     word.data[l] = cfg_sum(cfg_reg, 5'(l));
                  end
               end
               if (fr_reg == 5'h00) begin
                  word.data[l] = `ILC_K28_0;
                  word.is_k[l] = 1'b1;
               end
               if (fr_reg == cfg_reg.k_m1) begin
                  word.data[l] = `ILC_K28_3;
                  word.is_k[l] = 1'b1;
               end
            end
            if (push) begin
               fr_next = fr_reg + 5'h01;
               if (fr_reg == cfg_reg.k_m1) begin
                  fr_next = 5'h00;
                  mf_next = mf_reg + 2'h1;
                  if (mf_reg == 2'(`ILC_ILA_MF - 1)) begin
                     st_next = ILC_DATA;
                  end
               end
            end
         end
         default: begin
            word = data_in;
            push = fifo_in_ready;
         end
      endcase
      // Receiver reasserting sync restarts code group synchronisation.
      if (!s2_reg) begin
         st_next = ILC_CGS;
      end
   end

   // Output stage keeps every top-level output on a flip-flop.
   always_comb begin
      out_next = out_reg;
      ov_next  = ov_reg;
      if (!ov_reg || lane_ready) begin
         out_next = fifo_out;
         ov_next  = fifo_out_valid;
      end
      up_next  = (st_next == ILC_DATA);
      ila_next = (st_next == ILC_ILA);
      // The fill copy lets data_ready promise the next push exactly; a registered copy of the
      // FIFO's own ready would lag a cycle and drop or invent user words under back-pressure.
      fifo_pop  = fifo_out_valid && (!ov_reg || lane_ready);
      fill_next = fill_reg + 3'(push) - 3'(fifo_pop);
      rdy_next  = (st_next == ILC_DATA) && (fill_next != 3'(`ILC_FIFO_DEPTH));
   end

   // Registers only; every next value comes from the two processes above.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_reg  <= ILC_CGS;
         mf_reg  <= 2'h0;
         fr_reg  <= 5'h00;
         cfg_reg <= '{f_m1: `ILC_RST_F, k_m1: `ILC_RST_K, m_m1: `ILC_RST_M,
                      s_m1: `ILC_RST_S, scr: 1'b0, phadj: 1'b0};
         out_reg <= '0;
         ov_reg  <= 1'b0;
         up_reg  <= 1'b0;
         ila_reg <= 1'b0;
         data_ready <= 1'b0;
         fill_reg <= 3'h0;
      end else begin
         st_reg  <= st_next;
         mf_reg  <= mf_next;
         fr_reg  <= fr_next;
         cfg_reg <= cfg_next;
         out_reg <= out_next;
         ov_reg  <= ov_next;
         up_reg  <= up_next;
         ila_reg <= ila_next;
         data_ready <= rdy_next;
         fill_reg <= fill_next;
      end
   end

   ilc_fifo #(
      .WIDTH ($bits(ilc_word_t)),
      .DEPTH (`ILC_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .arst_n    (arst_n),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (word),
      .out_valid (fifo_out_valid),
      .out_ready (!ov_reg || lane_ready),
      .out_data  (fifo_out)
   );

   assign lane_out   = out_reg;
   assign lane_valid = ov_reg;
   assign link_up    = up_reg;
   assign ila_active = ila_reg;
endmodule
`default_nettype wire

// [design/ilc_pkg.sv]
// Types for the four-lane link configuration framer.
`default_nettype none
package ilc_pkg;
   // One octet on all four lanes, with control-character flags.
   typedef struct packed {
      logic [3:0][7:0] data;
      logic [3:0]      is_k;
   } ilc_word_t;
   // Link parameters that software-side logic may program.
   typedef struct packed {
      logic [7:0] f_m1;
      logic [4:0] k_m1;
      logic [7:0] m_m1;
      logic [4:0] s_m1;
      logic       scr;
      logic       phadj;
   } ilc_cfg_t;
   typedef enum logic [1:0] {ILC_CGS, ILC_WAIT, ILC_ILA, ILC_DATA} ilc_state_t;
endpackage
`default_nettype wire

// [sim/ilc_framer_asserts.sv]
// Port-level checker for the link configuration framer.
`default_nettype none
module ilc_framer_asserts (
   input wire logic               clk_sys,
   input wire logic               arst_n,
   input wire logic               sync_n,
   input wire logic               mf_start,
   input wire logic               data_ready,
   input wire ilc_pkg::ilc_word_t lane_out,
   input wire logic               lane_valid,
   input wire logic               lane_ready,
   input wire logic               ila_active,
   input wire logic               link_up
);
   import ilc_pkg::*;
   logic [3:0] lo_reg, lo_next;
   logic [7:0] ia_reg, ia_next;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Handshakes under a held sync, and cycles of alignment; both saturate.
   always_comb begin
      lo_next = sync_n ? 4'h0 : lo_reg + {3'h0, lane_valid && lane_ready && lo_reg != 4'hF};
      ia_next = ila_active ? ia_reg + {7'h0, ia_reg != 8'hFF} : 8'h00;
   end
   // Registers only.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         lo_reg <= 4'h0;
         ia_reg <= 8'h00;
      end else begin
         lo_reg <= lo_next;
         ia_reg <= ia_next;
      end
   end
   // Twelve handshakes allow for stale words still queued when sync fell.
   property p_comma;
      lo_reg >= 4'hC && lane_valid |-> lane_out.data == {4{8'hBC}} && lane_out.is_k == 4'hF;
   endproperty
   a_comma: assert property (p_comma) else $error("lane left commas under sync");
   property p_drop; !sync_n [*5] |-> !link_up && !ila_active; endproperty
   a_drop: assert property (p_drop) else $error("link kept up under sync");
   property p_start; $rose(ila_active) |-> sync_n && ($past(mf_start) || $past(mf_start, 2)); endproperty
   a_start: assert property (p_start) else $error("alignment off a boundary");
   property p_link; $rose(link_up) |-> $past(ila_active); endproperty
   a_link: assert property (p_link) else $error("data without alignment");
   property p_len; $fell(ila_active) && link_up |-> ia_reg >= 8'h40; endproperty
   a_len: assert property (p_len) else $error("alignment too short");
   property p_stand; lane_valid && !lane_ready |=> lane_valid && $stable(lane_out); endproperty
   a_stand: assert property (p_stand) else $error("word changed while stalled");
   property p_gate; !link_up [*2] |-> !data_ready; endproperty
   a_gate: assert property (p_gate) else $error("data taken outside data phase");
   property p_live; (!sync_n && lane_ready) [*8] |-> lane_valid || $past(lane_valid); endproperty
   a_live: assert property (p_live) else $error("no commas sent");
   c_ila: cover property ($rose(ila_active));
   c_link: cover property ($rose(link_up));
   c_stall: cover property (lane_valid && !lane_ready);
endmodule
`default_nettype wire

// [sim/ilc_framer_tb.sv]
// Self-checking bench for the four-lane link configuration framer.
`default_nettype none
module ilc_framer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ilc_pkg::*;
   localparam ilc_word_t comma_w = {{4{8'hBC}}, 4'hF};
   logic      clk_sys, arst_n, mf_start, cfg_load, go, slow;
   logic      sync_n, data_ready, lane_valid, lane_ready, ila_active, link_up;
   ilc_cfg_t  cfg_in, cur, x;
   ilc_word_t data_in, lane_out, w;
   ilc_word_t rxq[$], expq[$];
   int        num_errors, check_count, cyc, mfc;
   ilc_framer dut (.clk_sys(clk_sys), .arst_n(arst_n), .sync_n(sync_n), .mf_start(mf_start),
      .cfg_load(cfg_load), .cfg_in(cfg_in), .data_in(data_in), .data_ready(data_ready),
      .lane_out(lane_out), .lane_valid(lane_valid), .lane_ready(lane_ready),
      .ila_active(ila_active), .link_up(link_up));
   ilc_rx_model u_rx (.clk_sys(clk_sys), .arst_n(arst_n), .lane_out(lane_out),
      .lane_valid(lane_valid), .go(go), .slow(slow), .sync_n(sync_n), .lane_ready(lane_ready));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Capture, multiframe marks, random user data and the hang limit.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         num_errors++;
         $display("unexpected at %0t: run limit reached", $time);
         complete_run();
      end
      if (arst_n && lane_valid && lane_ready) rxq.push_back(lane_out);
      if (arst_n && data_ready) expq.push_back(data_in);
      mfc <= (mfc >= cur.k_m1) ? 0 : mfc + 1;
      mf_start <= #1 (mfc == 0);
      data_in <= #1 {$urandom, 4'h0};
   end
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk_word(ilc_word_t g, ilc_word_t e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: word %h want %h", $time, g, e);
      end
   endtask
   task automatic chk_flag(logic g, logic e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: flag %b want %b", $time, g, e);
      end
   endtask
   task automatic pop(output ilc_word_t o);
      wait (rxq.size() > 0);
      o = rxq.pop_front();
   endtask
   // Checksum is the sum of the fields, not of the octets; truncation gives mod 256.
   function automatic logic [7:0] octet(ilc_cfg_t c, logic [4:0] l, int i);
      logic [7:0] o[14];
      o = '{8'h00, 8'h00, {2'h0, c.phadj, l}, {c.scr, 7'h03}, c.f_m1, {3'h0, c.k_m1}, c.m_m1,
            8'h0F, 8'h4F, {3'h1, c.s_m1}, 8'h80, 8'h00, 8'h00, 8'h00};
      o[13] = c.phadj + l + c.scr + 8'h03 + c.f_m1 + c.k_m1 + c.m_m1 + 8'h22 + c.s_m1;
      return o[i];
   endfunction
   function automatic ilc_word_t cfg_word(ilc_cfg_t c, int i);
      for (int l = 0; l < 4; l++) cfg_word.data[l] = octet(c, l[4:0], i);
      cfg_word.is_k = 4'h0;
   endfunction
   // Releases sync, then walks the four alignment multiframes and some user data.
   task automatic run_ila(ilc_cfg_t c);
      int k1;
      k1 = c.k_m1 + 1;
      @(posedge clk_sys);
      #1 go = 1'b1;
      pop(w);
      while (w === comma_w) pop(w);
      chk_flag(ila_active, 1'b1);
      for (int i = 0; i < 4 * k1; i++) begin
         automatic int f = i % k1;
         if (f == 0) chk_word(w, {{4{8'h1C}}, 4'hF});
         else if (f == k1 - 1) chk_word(w, {{4{8'h7C}}, 4'hF});
         else if (i / k1 == 1 && f == 1) chk_word(w, {{4{8'h9C}}, 4'hF});
         else if (i / k1 == 1 && f < 16) chk_word(w, cfg_word(c, f - 2));
         if (i < 4 * k1 - 1) pop(w);
      end
      chk_flag(link_up, 1'b1);
      for (int i = 0; i < 30; i++) begin
         pop(w);
         chk_word(w, expq.pop_front());
      end
   endtask
   // Pulls sync low and checks that commas return once the queue has drained.
   task automatic resync();
      @(posedge clk_sys);
      #1 go = 1'b0;
      repeat (40) @(posedge clk_sys);
      #1 rxq.delete();
      expq.delete();
      pop(w);
      chk_word(w, comma_w);
      chk_flag(link_up, 1'b0);
   endtask
   task automatic load(ilc_cfg_t c);
      @(posedge clk_sys);
      #1 cfg_in = c;
      cfg_load = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 cfg_load = 1'b0;
   endtask
   initial begin
      void'($urandom(32'hB708));
      {arst_n, cfg_load, go, slow} = '0;
      cfg_in = '0;
      cur = '{8'h00, 5'h10, 8'h01, 5'h00, 1'b0, 1'b0};
      repeat (4) @(posedge clk_sys);
      chk_flag(lane_valid, 1'b0);
      #1 arst_n = 1'b1;
      repeat (20) @(posedge clk_sys);
      pop(w);
      chk_word(w, comma_w);
      slow = 1'b1;
      run_ila(cur);
      x = ilc_cfg_t'($urandom);
      x.k_m1 = 5'h0F + 5'($urandom_range(16));
      load(x);
      resync();
      run_ila(cur);
      for (int t = 0; t < 3; t++) begin
         resync();
         cur = ilc_cfg_t'($urandom);
         cur.k_m1 = 5'h0F + 5'($urandom_range(16));
         if (t == 0) cur = '{8'hFF, 5'h0F, 8'hFF, 5'h1F, 1'b1, 1'b1};
         slow = t[0];
         load(cur);
         run_ila(cur);
      end
      complete_run();
   end
endmodule
bind ilc_framer ilc_framer_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n), .sync_n(sync_n),
   .mf_start(mf_start), .data_ready(data_ready), .lane_out(lane_out), .lane_valid(lane_valid),
   .lane_ready(lane_ready), .ila_active(ila_active), .link_up(link_up));
`default_nettype wire

// [sim/ilc_rx_model.sv]
// Receiver model: releases sync after seeing commas, stalls at random.
`include "ilc_consts.svh"
`default_nettype none
module ilc_rx_model (
   input  wire logic               clk_sys,
   input  wire logic               arst_n,
   input  wire ilc_pkg::ilc_word_t lane_out,
   input  wire logic               lane_valid,
   input  wire logic               go,
   input  wire logic               slow,
   output logic                    sync_n,
   output logic                    lane_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   import ilc_pkg::*;
   int commas;
   // Sync stays low until four comma words arrived, so alignment never starts early.
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         commas <= 0;
         sync_n <= 1'b0;
         lane_ready <= 1'b0;
      end else begin
         if (lane_valid && lane_ready && lane_out.data == {4{`ILC_K28_5}}) commas <= commas + 1;
         if (!go) commas <= 0;
         sync_n <= go && commas >= 4;
         lane_ready <= !slow || $urandom_range(1) == 1;
      end
   end
endmodule
`default_nettype wire
